// [hdl/hbs_defs.svh]
// Constants of the host select and clear-to-send status block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef HBS_DEFS_SVH
`define HBS_DEFS_SVH

// Register indices on the three select lines
`define HBS_IDX_DIV_LO     3'h0
`define HBS_IDX_DIV_HI     3'h1
`define HBS_IDX_INT_EN     3'h1
`define HBS_IDX_LINE_CTL   3'h3
`define HBS_IDX_MODEM_CTL  3'h4
`define HBS_IDX_MODEM_STAT 3'h6

// Field positions
`define HBS_LINE_DIVACC_BIT 7
`define HBS_INT_MODEM_BIT   3
`define HBS_MCTL_AUTO_BIT   5
`define HBS_MSTAT_CTS_BIT   4
`define HBS_MSTAT_DCTS_BIT  0

// Reset values, then the divider constants one and zero
`define HBS_DIV_RST   16'h0001
`define HBS_BYTE_RST  8'h00
`define HBS_IDX_RST   3'h0
`define HBS_CNT_RST   16'h0000
`define HBS_DIV_ONE   16'h0001
`define HBS_DIV_ZERO  16'h0000

// Divisor that the rate period self-check watches; its depth of 5 must match
`define HBS_CHK_DIV   16'h0005

`endif

// [hdl/hbs_pkg.sv]
// Types shared by the host select and clear-to-send status block.
// Assumes hbs_defs.svh is compiled alongside; holds types only.
package hbs_pkg;

  // One set of select inputs as seen by the decode logic
  typedef struct packed {
    logic [2:0] idx;   // Register index
    logic       cs_a;  // First chip select, active high
    logic       cs_b;  // Second chip select, active high
    logic       cs_n;  // Third chip select, active low
  } hbs_sel_type;

  // Clear-to-send status as reported to the host
  typedef struct packed {
    logic level;  // Input asserted
    logic delta;  // Changed since last status read
    logic irq;    // Modem status interrupt request
  } hbs_cts_type;

endpackage

// [hdl/hbs_rate_gen.sv]
// Programmable divider that makes the 16x rate tick from core_clk.
// Assumes the divisor is held stable by the host between writes.
`timescale 1ns/1ps
`include "hbs_defs.svh"

module hbs_rate_gen
  import hbs_pkg::*;
#(
  parameter int DIV_W = 16  // Divisor width
) (
  input  wire logic             core_clk,  // Reference clock
  input  wire logic             nrst,      // Synchronous reset, active low
  input  wire logic [DIV_W-1:0] divisor,   // Division factor, 0 stops the tick
  output logic                  tick       // One cycle every divisor cycles
);

  logic [DIV_W-1:0] cnt_q;   // Cycle counter
  logic [DIV_W-1:0] cnt_d;   // Next counter value
  logic             tick_q;  // Registered tick
  logic             tick_d;  // Next tick
  logic             wrap;    // Counter reached the end of a period

  // Count 0..divisor-1; using >= lets a smaller new divisor take hold at once
  always_comb begin
    wrap   = (divisor != DIV_W'(`HBS_DIV_ZERO)) &&
             (cnt_q >= divisor - DIV_W'(`HBS_DIV_ONE));
    cnt_d  = wrap ? DIV_W'(`HBS_CNT_RST) : cnt_q + DIV_W'(`HBS_DIV_ONE);
    tick_d = wrap;
    if (divisor == DIV_W'(`HBS_DIV_ZERO)) begin
      cnt_d = DIV_W'(`HBS_CNT_RST);  // Zero is outside the legal range: hold still
    end
  end

  // Register the counter and tick
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cnt_q  <= DIV_W'(`HBS_CNT_RST);
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule

// [hdl/hbs_cts_status.sv]
// Clear-to-send level, change flag and interrupt request.
// Assumes cts_n is already synchronous to core_clk.
`timescale 1ns/1ps
`include "hbs_defs.svh"

module hbs_cts_status
  import hbs_pkg::*;
(
  input  wire logic core_clk,      // Reference clock
  input  wire logic nrst,          // Synchronous reset, active low
  input  wire logic cts_n,         // Clear-to-send input, active low
  input  wire logic stat_rd_done,  // Pulse: host finished reading modem status
  input  wire logic modem_int_en,  // Modem status interrupt enable
  input  wire logic auto_cts_en,   // Automatic flow control on
  output hbs_cts_type stat         // Level, change flag, interrupt
);

  logic prev_q;    // Input one cycle ago
  logic prev_d;    // Next previous value
  logic seen_q;    // Previous value is meaningful
  logic seen_d;    // Next seen flag
  logic delta_q;   // Sticky change flag
  logic delta_d;   // Next change flag
  logic changed;   // Input moved this cycle

  // Change detect; set beats clear so no edge is lost during a status read
  always_comb begin
    changed = seen_q && (cts_n != prev_q);
    prev_d  = cts_n;
    seen_d  = 1'b1;
    delta_d = delta_q;
    if (stat_rd_done) begin
      delta_d = 1'b0;
    end
    if (changed) begin
      delta_d = 1'b1;
    end
  end

  // Register the change state
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      prev_q  <= 1'b1;
      seen_q  <= 1'b0;
      delta_q <= 1'b0;
    end else begin
      prev_q  <= prev_d;
      seen_q  <= seen_d;
      delta_q <= delta_d;
    end
  end

  assign stat.level = ~cts_n;
  assign stat.delta = delta_q;
  assign stat.irq   = delta_q && modem_int_en && !auto_cts_en;

endmodule

// [hdl/hbs_host_port.sv]
// Host select logic, register access, 16x rate clock and clear-to-send
// status of the serial element's processor port.
// Assumes host strobes and selects are synchronous to core_clk and that
// the outside world resolves the data wire from host_bus_oe.
`timescale 1ns/1ps
`include "hbs_defs.svh"

module hbs_host_port
  import hbs_pkg::*;
#(
  parameter int DIV_W  = 16,  // Divisor width
  parameter int DATA_W = 8    // Host data width
) (
  input  wire logic              core_clk,               // Reference clock
  input  wire logic              nrst,                   // Sync reset, active low
  input  wire logic              reg_index_bit0,         // Register index bit 0
  input  wire logic              reg_index_bit1,         // Register index bit 1
  input  wire logic              reg_index_bit2,         // Register index bit 2
  input  wire logic              select_latch_strobe_n,  // Select latch strobe
  input  wire logic              chip_sel_hi_a,          // Chip select, active high
  input  wire logic              chip_sel_hi_b,          // Chip select, active high
  input  wire logic              chip_sel_lo_n,          // Chip select, active low
  input  wire logic              host_rd_n,              // Read strobe, active low
  input  wire logic              host_wr_n,              // Write strobe, active low
  input  wire logic [DATA_W-1:0] host_bus_in,            // Data bus, wire level
  output logic      [DATA_W-1:0] host_bus_out,           // Data bus, driven value
  output logic                   host_bus_oe,            // Data bus drive enable
  input  wire logic              cts_n,                  // Clear to send, active low
  output logic                   rate_clock_x16_out,     // 16x rate tick
  output logic                   tx_allow,               // Transmitter may send
  output logic                   modem_irq               // Modem status interrupt
);

  // Select path state
  hbs_sel_type live_sel;   // Selects as on the pins now
  hbs_sel_type held_q;     // Selects caught at strobe rise
  hbs_sel_type held_d;     // Next held selects
  hbs_sel_type eff_sel;    // Selects used by the decode
  logic        strobe_q;   // Strobe one cycle ago
  logic        strobe_d;   // Next strobe history
  logic        strobe_rise;  // Strobe went low to high
  logic        sel_on;     // Device is selected

  // Register file state
  logic [DIV_W-1:0]  div_q;       // Rate divisor
  logic [DIV_W-1:0]  div_d;       // Next divisor
  logic [DATA_W-1:0] int_en_q;    // Interrupt enable
  logic [DATA_W-1:0] int_en_d;    // Next interrupt enable
  logic [DATA_W-1:0] line_q;      // Line control
  logic [DATA_W-1:0] line_d;      // Next line control
  logic [DATA_W-1:0] mctl_q;      // Modem control
  logic [DATA_W-1:0] mctl_d;      // Next modem control
  logic [DATA_W-1:0] rdata_q;     // Read data driven on the bus
  logic [DATA_W-1:0] rdata_d;     // Next read data
  logic              stat_rd_q;   // Modem status read in progress
  logic              stat_rd_d;   // Next status read flag
  logic              stat_rd_done;  // Status read just ended
  logic              div_acc;     // Divisor access bit
  logic              rd_on;       // Selected read this cycle
  logic              wr_on;       // Selected write this cycle
  logic [DATA_W-1:0] stat_byte;   // Modem status as read
  hbs_cts_type       cts_stat;    // Clear-to-send status
  logic              tick;        // Rate tick from divider

  // Pack byte halves of the divisor; used by the read mux only, writes slice div_d directly
  function automatic logic [DATA_W-1:0] div_byte(input logic [DIV_W-1:0] d,
                                                 input logic             hi);
    div_byte = hi ? d[DIV_W-1 -: DATA_W] : d[DATA_W-1:0];
  endfunction

  // Chip select decode, shared by live and held paths
  function automatic logic sel_match(input hbs_sel_type s);
    sel_match = s.cs_a && s.cs_b && !s.cs_n;
  endfunction

  assign live_sel.idx  = {reg_index_bit2, reg_index_bit1, reg_index_bit0};
  assign live_sel.cs_a = chip_sel_hi_a;
  assign live_sel.cs_b = chip_sel_hi_b;
  assign live_sel.cs_n = chip_sel_lo_n;

  // Select latch: transparent while the strobe is low, frozen while high.
  // The rise cycle itself uses the pins, which equal what is being caught.
  always_comb begin
    strobe_d    = select_latch_strobe_n;
    strobe_rise = select_latch_strobe_n && !strobe_q;
    held_d      = held_q;
    if (strobe_rise) begin
      held_d = live_sel;
    end
    if (!select_latch_strobe_n || strobe_rise) begin
      eff_sel = live_sel;
    end else begin
      eff_sel = held_q;
    end
    sel_on = sel_match(eff_sel);
  end

  // Register the select latch
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      strobe_q     <= 1'b1;
      held_q.idx   <= `HBS_IDX_RST;
      held_q.cs_a  <= 1'b0;
      held_q.cs_b  <= 1'b0;
      held_q.cs_n  <= 1'b1;
    end else begin
      strobe_q <= strobe_d;
      held_q   <= held_d;
    end
  end

  // Strobes only count while selected; otherwise the device sits idle
  assign rd_on   = sel_on && !host_rd_n;
  assign wr_on   = sel_on && !host_wr_n;
  assign div_acc = line_q[`HBS_LINE_DIVACC_BIT];

  // Status byte: only the clear-to-send fields live here, the rest read zero
  always_comb begin
    stat_byte                      = `HBS_BYTE_RST;
    stat_byte[`HBS_MSTAT_CTS_BIT]  = cts_stat.level;
    stat_byte[`HBS_MSTAT_DCTS_BIT] = cts_stat.delta;
  end

  // Register writes and read mux; index picks the target
  always_comb begin
    div_d     = div_q;
    int_en_d  = int_en_q;
    line_d    = line_q;
    mctl_d    = mctl_q;
    rdata_d   = rdata_q;
    stat_rd_d = rd_on && (eff_sel.idx == `HBS_IDX_MODEM_STAT);
    if (wr_on) begin
      unique case (eff_sel.idx)
        `HBS_IDX_DIV_LO: begin
          if (div_acc) begin
            div_d[DATA_W-1:0] = host_bus_in;
          end
        end
        `HBS_IDX_DIV_HI: begin
          if (div_acc) begin
            div_d[DIV_W-1 -: DATA_W] = host_bus_in;
          end else begin
            int_en_d = host_bus_in;
          end
        end
        `HBS_IDX_LINE_CTL:  line_d = host_bus_in;
        `HBS_IDX_MODEM_CTL: mctl_d = host_bus_in;
        default: ;  // Read-only or absent indices ignore writes
      endcase
    end
    if (rd_on) begin
      unique case (eff_sel.idx)
        `HBS_IDX_DIV_LO:     rdata_d = div_acc ? div_byte(div_q, 1'b0) : `HBS_BYTE_RST;
        `HBS_IDX_DIV_HI:     rdata_d = div_acc ? div_byte(div_q, 1'b1) : int_en_q;
        `HBS_IDX_LINE_CTL:   rdata_d = line_q;
        `HBS_IDX_MODEM_CTL:  rdata_d = mctl_q;
        `HBS_IDX_MODEM_STAT: rdata_d = stat_byte;
        default:             rdata_d = `HBS_BYTE_RST;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      div_q     <= DIV_W'(`HBS_DIV_RST);
      int_en_q  <= `HBS_BYTE_RST;
      line_q    <= `HBS_BYTE_RST;
      mctl_q    <= `HBS_BYTE_RST;
      rdata_q   <= `HBS_BYTE_RST;
      stat_rd_q <= 1'b0;
    end else begin
      div_q     <= div_d;
      int_en_q  <= int_en_d;
      line_q    <= line_d;
      mctl_q    <= mctl_d;
      rdata_q   <= rdata_d;
      stat_rd_q <= stat_rd_d;
    end
  end

  // Clear on the end of the read, so the host has seen the flag first
  assign stat_rd_done = stat_rd_q && !stat_rd_d;

  // Data bus: drive only during a selected read; the read byte trails by
  // one cycle, so hosts must sample at least one cycle into the read
  assign host_bus_out = rdata_q;
  assign host_bus_oe  = rd_on;

  // Rate divider
  hbs_rate_gen #(
    .DIV_W (DIV_W)
  ) u_rate (
    .core_clk (core_clk),
    .nrst     (nrst),
    .divisor  (div_q),
    .tick     (tick)
  );

  // Clear-to-send status
  hbs_cts_status u_cts (
    .core_clk     (core_clk),
    .nrst         (nrst),
    .cts_n        (cts_n),
    .stat_rd_done (stat_rd_done),
    .modem_int_en (int_en_q[`HBS_INT_MODEM_BIT]),
    .auto_cts_en  (mctl_q[`HBS_MCTL_AUTO_BIT]),
    .stat         (cts_stat)
  );

  assign rate_clock_x16_out = tick;
  // Transmitter may send freely unless auto mode waits on the input
  assign tx_allow  = !mctl_q[`HBS_MCTL_AUTO_BIT] || cts_stat.level;
  assign modem_irq = cts_stat.irq;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  chk_sel_pass_live: assert property (
    !select_latch_strobe_n |-> sel_on == sel_match(live_sel))
    else $error("Live selects not passed while strobe low");

  chk_sel_capture: assert property (
    $rose(select_latch_strobe_n) |=> held_q == $past(live_sel))
    else $error("Selects not caught at strobe rise");

  chk_sel_hold: assert property (
    select_latch_strobe_n && $past(select_latch_strobe_n) |-> eff_sel == $past(eff_sel))
    else $error("Selects moved while strobe high");

  chk_idle_unsel: assert property (
    !sel_match(eff_sel) |-> !host_bus_oe ##1 (div_q == $past(div_q)))
    else $error("Activity while not selected");

  chk_status_level: assert property (
    rd_on && eff_sel.idx == `HBS_IDX_MODEM_STAT
      |=> rdata_q[`HBS_MSTAT_CTS_BIT] == !$past(cts_n))
    else $error("Status bit does not show clear-to-send");

  // The flag must show the change and keep it unless a status read just ended
  chk_delta_set: assert property (
    $past(nrst) && cts_n != $past(cts_n)
      |=> cts_stat.delta ##1 (cts_stat.delta || $past(stat_rd_done)))
    else $error("Change flag missed an input change");

  chk_delta_clear: assert property (
    stat_rd_done && !(cts_n != $past(cts_n)) && $stable(cts_n) [*1] ##1 $stable(cts_n)
      |-> !cts_stat.delta)
    else $error("Change flag not cleared by status read");

  chk_irq_gate: assert property (
    mctl_q[`HBS_MCTL_AUTO_BIT] || !int_en_q[`HBS_INT_MODEM_BIT] |-> !modem_irq)
    else $error("Interrupt raised while gated off");

  chk_tx_hold: assert property (
    mctl_q[`HBS_MCTL_AUTO_BIT] && cts_n |-> !tx_allow)
    else $error("Transmitter not held in auto mode");

  // Looks backwards, so a divisor write right after a tick cannot trip it
  chk_rate_period: assert property (
    (div_q == DIV_W'(`HBS_CHK_DIV)) [*7] ##0 rate_clock_x16_out
      |-> $past(rate_clock_x16_out, 5) && !$past(rate_clock_x16_out, 1) &&
          !$past(rate_clock_x16_out, 2) && !$past(rate_clock_x16_out, 3) &&
          !$past(rate_clock_x16_out, 4))
    else $error("Rate tick period differs from divisor");

  chk_div_write: assert property (
    wr_on && div_acc && eff_sel.idx == `HBS_IDX_DIV_LO
      |=> div_q[DATA_W-1:0] == $past(host_bus_in))
    else $error("Divisor low byte not written");

  chk_delta_hold: assert property (
    cts_stat.delta && !stat_rd_done |=> cts_stat.delta)
    else $error("Change flag lost without a status read");

  chk_irq_raise: assert property (
    cts_stat.delta && int_en_q[`HBS_INT_MODEM_BIT] && !mctl_q[`HBS_MCTL_AUTO_BIT]
      |-> modem_irq)
    else $error("Interrupt missing after a change");

  chk_rd_line: assert property (
    rd_on && eff_sel.idx == `HBS_IDX_LINE_CTL |=> host_bus_out == $past(line_q))
    else $error("Read byte not driven on the bus");

  cov_latch_used: cover property (
    $rose(select_latch_strobe_n) ##1 rd_on);
  cov_delta_read: cover property (
    cts_stat.delta ##[1:20] stat_rd_done);
  cov_auto_hold: cover property (
    mctl_q[`HBS_MCTL_AUTO_BIT] && !tx_allow);

endmodule

// [test/hbs_host_model.sv]
// Host processor model that drives the select, strobe and data pins.
// Assumes the bench resolves the data wire and calls one task at a time.
`timescale 1ns/1ps
`include "hbs_defs.svh"

module hbs_host_model
  import hbs_pkg::*;
(
  input  wire logic       core_clk,  // Reference clock
  input  wire logic       dev_oe,    // Device drives the wire
  input  wire logic [7:0] bus_wire,  // Resolved data wire
  output hbs_sel_type     sel,       // Select pins
  output logic            strobe_n,  // Select latch strobe, active low
  output logic            rd_n,      // Read strobe, active low
  output logic            wr_n,      // Write strobe, active low
  output logic [7:0]      drv_data   // Host drive value
);
  // Idle: deselected, strobe low so selects stay live
  initial begin
    sel = '{idx: 3'h7, cs_a: 1'b0, cs_b: 1'b0, cs_n: 1'b1};
    strobe_n = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    drv_data = 8'h00;
  end

  // Strobe low with selects, rise to capture, then let pins wander
  task automatic latch(input hbs_sel_type s);
    @(posedge core_clk);
    strobe_n <= 1'b0;
    sel <= s;
    @(posedge core_clk);
    strobe_n <= 1'b1;
    @(posedge core_clk);
    sel <= hbs_sel_type'(~s);
  endtask

  // One access; live=0 keeps the strobe high so held selects apply
  task automatic acc(input logic wr, input logic live, input hbs_sel_type s,
                     input logic [7:0] wd, output logic [7:0] rd, output logic oe);
    @(posedge core_clk);
    if (live) begin
      strobe_n <= 1'b0;
    end
    sel <= s;
    if (wr) begin
      wr_n <= 1'b0;
      drv_data <= wd;
    end else begin
      rd_n <= 1'b0;
    end
    @(posedge core_clk);
    if (wr) begin
      wr_n <= 1'b1;
      drv_data <= ~wd;  // A released wire must not keep the last byte
      rd = 8'h00;
      oe = 1'b0;
    end else begin
      // Read data is valid from the second cycle of the read
      @(posedge core_clk);
      rd = bus_wire;
      oe = dev_oe;
      rd_n <= 1'b1;
    end
  endtask
endmodule

// [test/tb_host_bus_select_and_cts_status.sv]
// Self-checking bench for the host select port and clear-to-send status.
// Assumes the host model file and the design files are compiled before it.
`timescale 1ns/1ps
`include "hbs_defs.svh"

module tb_host_bus_select_and_cts_status;
  import hbs_pkg::*;
  logic        core_clk;   // 200 MHz reference
  logic        nrst;       // Sync reset, active low
  logic        cts_n;      // Clear to send, active low
  hbs_sel_type sel;        // Select pins from the host
  logic        strobe_n;   // Select latch strobe
  logic        rd_n;       // Read strobe
  logic        wr_n;       // Write strobe
  logic        oe;         // Device drive enable
  logic        rate_tick;  // 16x rate tick
  logic        tx_allow;   // Transmitter allowed
  logic        modem_irq;  // Modem status interrupt
  logic [7:0]  drv_data;   // Host drive value
  logic [7:0]  bus_out;    // Device drive value
  logic [7:0]  bus_wire;   // Resolved wire
  int          n_fail;     // Mismatches
  int          compares;   // Comparisons made

  // Wire level: the device wins while enabled, else the host value
  assign bus_wire = oe ? bus_out : drv_data;

  always #2.5 core_clk = ~core_clk;

  hbs_host_port hbs_host_port_i (
    .core_clk(core_clk),
    .nrst(nrst),
    .reg_index_bit0(sel.idx[0]),
    .reg_index_bit1(sel.idx[1]),
    .reg_index_bit2(sel.idx[2]),
    .select_latch_strobe_n(strobe_n),
    .chip_sel_hi_a(sel.cs_a),
    .chip_sel_hi_b(sel.cs_b),
    .chip_sel_lo_n(sel.cs_n),
    .host_rd_n(rd_n),
    .host_wr_n(wr_n),
    .host_bus_in(bus_wire),
    .host_bus_out(bus_out),
    .host_bus_oe(oe),
    .cts_n(cts_n),
    .rate_clock_x16_out(rate_tick),
    .tx_allow(tx_allow),
    .modem_irq(modem_irq)
  );

  hbs_host_model hbs_host_model_i (
    .core_clk(core_clk),
    .dev_oe(oe),
    .bus_wire(bus_wire),
    .sel(sel),
    .strobe_n(strobe_n),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .drv_data(drv_data)
  );

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input logic [16:0] got, input logic [16:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Fully selected pins for one register index
  function automatic hbs_sel_type pick(input logic [2:0] i);
    return '{idx: i, cs_a: 1'b1, cs_b: 1'b1, cs_n: 1'b0};
  endfunction

  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    logic [7:0] r;
    logic       o;
    hbs_host_model_i.acc(1'b1, 1'b1, pick(i), d, r, o);
  endtask

  task automatic rd_chk(input logic [2:0] i, input logic [7:0] exp);
    logic [7:0] r;
    logic       o;
    hbs_host_model_i.acc(1'b0, 1'b1, pick(i), 8'h00, r, o);
    chk_byte(r, exp);
    chk_bit(o, 1'b1);
  endtask

  task automatic t_reset();
    chk_bit(tx_allow, 1'b1);
    chk_bit(modem_irq, 1'b0);
    chk_bit(oe, 1'b0);
  endtask

  // Index decode, divisor access gate, unused index
  task automatic t_regs();
    wr(`HBS_IDX_LINE_CTL, 8'h80);
    wr(`HBS_IDX_DIV_LO, 8'hA5);
    wr(`HBS_IDX_DIV_HI, 8'h3C);
    rd_chk(`HBS_IDX_DIV_LO, 8'hA5);
    rd_chk(`HBS_IDX_DIV_HI, 8'h3C);
    rd_chk(`HBS_IDX_LINE_CTL, 8'h80);
    wr(`HBS_IDX_LINE_CTL, 8'h00);
    wr(`HBS_IDX_INT_EN, 8'h08);
    rd_chk(`HBS_IDX_DIV_LO, 8'h00);
    rd_chk(`HBS_IDX_INT_EN, 8'h08);
    rd_chk(3'h2, 8'h00);
  endtask

  // Every chip-select combination; only high, high, low may act
  task automatic t_select();
    hbs_sel_type s;
    logic [7:0]  r;
    logic        o;
    for (int c = 0; c < 8; c++) begin
      s = pick(`HBS_IDX_MODEM_CTL);
      {s.cs_a, s.cs_b, s.cs_n} = 3'(c);
      hbs_host_model_i.acc(1'b1, 1'b1, s, 8'h20, r, o);
      hbs_host_model_i.acc(1'b0, 1'b1, s, 8'h00, r, o);
      chk_bit(o, c == 6);
      rd_chk(`HBS_IDX_MODEM_CTL, (c == 6) ? 8'h20 : 8'h00);
      wr(`HBS_IDX_MODEM_CTL, 8'h00);
    end
  endtask

  // Held selects drive a write and read while pins show nonsense
  task automatic t_latch();
    hbs_sel_type junk;
    logic [7:0]  r;
    logic        o;
    junk = '{idx: 3'h0, cs_a: 1'b0, cs_b: 1'b0, cs_n: 1'b1};
    hbs_host_model_i.latch(pick(`HBS_IDX_MODEM_CTL));
    hbs_host_model_i.acc(1'b1, 1'b0, junk, 8'h20, r, o);
    hbs_host_model_i.acc(1'b0, 1'b0, junk, 8'h00, r, o);
    chk_byte(r, 8'h20);
    chk_bit(o, 1'b1);
    wr(`HBS_IDX_MODEM_CTL, 8'h00);
    rd_chk(`HBS_IDX_MODEM_CTL, 8'h00);
  endtask

  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rate_tick !== 1'b1 && n < 70000);
  endtask

  // First tick may straddle the change; the next interval is measured
  task automatic t_rate(input logic [15:0] div);
    int n;
    wr(`HBS_IDX_LINE_CTL, 8'h80);
    wr(`HBS_IDX_DIV_HI, div[15:8]);
    wr(`HBS_IDX_DIV_LO, div[7:0]);
    wr(`HBS_IDX_LINE_CTL, 8'h00);
    wait_tick(n);
    wait_tick(n);
    chk_cnt(n[16:0], {1'b0, div});
  endtask

  task automatic t_cts();
    wr(`HBS_IDX_MODEM_CTL, 8'h00);
    rd_chk(`HBS_IDX_MODEM_STAT, 8'h00);
    @(posedge core_clk);
    cts_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk_bit(modem_irq, 1'b1);
    rd_chk(`HBS_IDX_MODEM_STAT, 8'h11);
    repeat (3) @(posedge core_clk);
    chk_bit(modem_irq, 1'b0);
    rd_chk(`HBS_IDX_MODEM_STAT, 8'h10);
    wr(`HBS_IDX_MODEM_CTL, 8'h20);
    @(posedge core_clk);
    chk_bit(tx_allow, 1'b1);
    @(posedge core_clk);
    cts_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk_bit(tx_allow, 1'b0);
    chk_bit(modem_irq, 1'b0);
    rd_chk(`HBS_IDX_MODEM_STAT, 8'h01);
    @(posedge core_clk);
    cts_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk_bit(tx_allow, 1'b1);
    wr(`HBS_IDX_MODEM_CTL, 8'h00);
    // Let each write land before looking at the interrupt it gates
    @(posedge core_clk);
    chk_bit(modem_irq, 1'b1);
    wr(`HBS_IDX_INT_EN, 8'h00);
    @(posedge core_clk);
    chk_bit(modem_irq, 1'b0);
    rd_chk(`HBS_IDX_MODEM_STAT, 8'h11);
  endtask

  task automatic results();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    cts_n = 1'b1;
    n_fail = 0;
    compares = 0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_regs();
    t_select();
    t_latch();
    t_rate(16'h0001);
    t_rate(16'h0002);
    t_rate(16'h0005);
    t_rate(16'h0103);
    t_cts();
    results();
  end

  // Whole run needs under a thousand cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    results();
  end
endmodule
